// file: potx_pkg.sv
// Shared constants and types of the quad potentiometer serial link
package potx_pkg;
	localparam int POTX_WIPER_W = 6;
	localparam int POTX_NPOT = 4;
	localparam int POTX_NSLOT = 4;
	localparam logic [5:0] POTX_WIPER_MAX = 6'h3f;
	localparam logic [5:0] POTX_WIPER_RST = 6'h00;
	localparam logic [5:0] POTX_STORE_RST = 6'h00;

	// Frame codes
	localparam logic [5:0] POTX_ADDR_PREFIX = 6'h14;
	localparam logic [7:0] POTX_OP_STATUS = 8'h51;
	localparam logic [3:0] POTX_OP_GRECALL = 4'h1;
	localparam logic [3:0] POTX_OP_GSAVE = 4'h8;
	localparam logic [3:0] POTX_OP_SSAVE = 4'he;
	localparam logic [3:0] POTX_OP_SRECALL = 4'hd;
	localparam logic [5:0] POTX_OP_STEP = 6'h08;

	// Timing
	localparam int POTX_CLK_NS = 50;
	localparam int POTX_PROG_NS = 5000000;
	localparam int POTX_PROG_CYC = POTX_PROG_NS / POTX_CLK_NS;
	localparam logic [3:0] POTX_SCK_HALF = 4'h8;

	// Controller registers (byte addresses)
	localparam logic [3:0] POTX_REG_CTRL = 4'h0;
	localparam logic [3:0] POTX_REG_STATUS = 4'h4;
	localparam logic [3:0] POTX_REG_IRQ_STAT = 4'h8;
	localparam logic [3:0] POTX_REG_IRQ_MASK = 4'hc;
	localparam int POTX_CTRL_OP_LSB = 0;
	localparam int POTX_CTRL_SLOT_LSB = 4;
	localparam int POTX_CTRL_POT_LSB = 8;
	localparam int POTX_CTRL_DEV_LSB = 12;
	localparam int POTX_CTRL_DIR_BIT = 16;
	localparam int POTX_CTRL_STEPS_LSB = 20;
	localparam int POTX_STAT_BUSY_BIT = 0;
	localparam int POTX_STAT_BYTE_LSB = 1;
	localparam logic POTX_IRQ_MASK_RST = 1'b0;

	typedef enum logic [2:0] {
		POTX_CMD_STATUS = 3'h0,
		POTX_CMD_GRECALL = 3'h1,
		POTX_CMD_GSAVE = 3'h2,
		POTX_CMD_SSAVE = 3'h3,
		POTX_CMD_SRECALL = 3'h4,
		POTX_CMD_STEP = 3'h5
	} potx_cmd_t;

	typedef logic [POTX_NPOT-1:0][POTX_WIPER_W-1:0] potx_wipers_t;
endpackage

// file: potx_if.sv
// Serial link between the potentiometer controller and the device
interface potx_if;
	logic cs_n;
	logic sck;
	logic si;
	logic so;
	modport dev (input cs_n, input sck, input si, output so);
	modport host (output cs_n, output sck, output si, input so);
endinterface

// file: potx_sync.sv
// Two-stage synchroniser for pins from outside the clock domain
module potx_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_r;

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			meta_r <= RST_VAL;
			q_o <= RST_VAL;
		end
		else if (ce_i)
		begin
			meta_r <= d_i;
			q_o <= meta_r;
		end
	end
endmodule

// file: potx_dev.sv
// Device end: serial command decoder, wipers and stored settings
module potx_dev
	import potx_pkg::*;
#(
	parameter int PROG_CYC = potx_pkg::POTX_PROG_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	potx_if.dev link,
	input wire logic addr_pin_high_i,
	input wire logic addr_pin_low_i,
	output potx_pkg::potx_wipers_t wiper_o,
	output logic write_busy_flag_o
);
	import potx_pkg::*;

	typedef enum logic [6:0] {
		DS_IDLE = 7'b0000001,
		DS_ADDR = 7'b0000010,
		DS_INSTR = 7'b0000100,
		DS_TX = 7'b0001000,
		DS_STEP = 7'b0010000,
		DS_WAIT = 7'b0100000,
		DS_SKIP = 7'b1000000
	} potx_dstate_t;

	logic [4:0] pins_s;
	logic s_cs_n;
	logic s_sck;
	logic s_si;
	logic [1:0] s_addr;
	logic sck_d_r;
	logic cs_d_r;
	logic sck_rise;
	logic sck_fall;
	logic cs_fall;
	logic cs_rise;
	potx_dstate_t st_r;
	logic [2:0] cnt_r;
	logic [7:0] shift_r;
	logic [7:0] rx_byte;
	logic [8:0] tx_r;
	logic pend_r;
	logic [3:0] pend_op_r;
	logic [1:0] slot_r;
	logic [1:0] pot_r;
	logic exec;
	logic save_go;
	logic [16:0] prog_cnt_r;
	logic [POTX_WIPER_W-1:0] store_r [POTX_NPOT][POTX_NSLOT];

	potx_sync #(
		.W(5),
		.RST_VAL(5'h04)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.d_i({addr_pin_high_i, addr_pin_low_i, link.cs_n, link.sck,
			link.si}),
		.q_o(pins_s)
	);

	assign s_addr = pins_s[4:3];
	assign s_cs_n = pins_s[2];
	assign s_sck = pins_s[1];
	assign s_si = pins_s[0];
	assign sck_rise = s_sck & ~sck_d_r & ~s_cs_n;
	assign sck_fall = ~s_sck & sck_d_r & ~s_cs_n;
	assign cs_fall = ~s_cs_n & cs_d_r;
	assign cs_rise = s_cs_n & ~cs_d_r;
	assign rx_byte = {shift_r[6:0], s_si};
	// Transfers run only on a clean frame end; a cycle in flight blocks them
	assign exec = cs_rise & pend_r & ~write_busy_flag_o;
	assign save_go = exec & (pend_op_r == POTX_OP_GSAVE
		|| pend_op_r == POTX_OP_SSAVE);
	assign link.so = tx_r[8];

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			sck_d_r <= 1'b0;
			cs_d_r <= 1'b1;
		end
		else if (ce_i)
		begin
			sck_d_r <= s_sck;
			cs_d_r <= s_cs_n;
		end
	end

	// Frame decoder
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			st_r <= DS_IDLE;
			cnt_r <= 3'h0;
			shift_r <= 8'h00;
			pend_r <= 1'b0;
			pend_op_r <= 4'h0;
			slot_r <= 2'h0;
			pot_r <= 2'h0;
		end
		else if (ce_i)
		begin
			if (s_cs_n)
			begin
				st_r <= DS_IDLE;
				if (cs_rise)
					pend_r <= 1'b0;
			end
			else if (cs_fall)
			begin
				st_r <= DS_ADDR;
				cnt_r <= 3'h0;
				pend_r <= 1'b0;
			end
			else if (sck_rise)
			begin
				shift_r <= rx_byte;
				cnt_r <= cnt_r + 3'h1;
				unique case (st_r)
					DS_ADDR:
						if (cnt_r == 3'h7)
						begin
							if (rx_byte == {POTX_ADDR_PREFIX, s_addr})
								st_r <= DS_INSTR;
							else
								st_r <= DS_SKIP;
						end
					DS_INSTR:
						if (cnt_r == 3'h7)
						begin
							slot_r <= rx_byte[3:2];
							pot_r <= rx_byte[1:0];
							pend_op_r <= rx_byte[7:4];
							if (rx_byte == POTX_OP_STATUS)
								st_r <= DS_TX;
							else if (rx_byte[7:2] == POTX_OP_STEP)
								st_r <= DS_STEP;
							else if ((rx_byte[7:4] == POTX_OP_GRECALL
								|| rx_byte[7:4] == POTX_OP_GSAVE)
								&& rx_byte[1:0] == 2'h0)
							begin
								st_r <= DS_WAIT;
								pend_r <= 1'b1;
							end
							else if (rx_byte[7:4] == POTX_OP_SSAVE
								|| rx_byte[7:4] == POTX_OP_SRECALL)
							begin
								st_r <= DS_WAIT;
								pend_r <= 1'b1;
							end
							else
								st_r <= DS_SKIP;
						end
					DS_WAIT:
					begin
						// A transfer frame longer than two bytes is discarded
						st_r <= DS_SKIP;
						pend_r <= 1'b0;
					end
					DS_TX, DS_STEP, DS_SKIP, DS_IDLE:
						st_r <= st_r;
				endcase
			end
		end
	end

	// Status bits leave on falls; spare top bit idles the first half clock
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			tx_r <= 9'h000;
		else if (ce_i)
		begin
			if (s_cs_n)
				tx_r <= 9'h000;
			else if (st_r == DS_INSTR && sck_rise && cnt_r == 3'h7)
				tx_r <= {8'h00, write_busy_flag_o};
			else if (st_r == DS_TX && sck_fall)
				tx_r <= {tx_r[7:0], 1'b0};
		end
	end

	// Wiper settings: stepping and recall
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			wiper_o <= {POTX_NPOT{POTX_WIPER_RST}};
		else if (ce_i)
		begin
			if (st_r == DS_STEP && sck_rise && !cs_fall)
			begin
				if (s_si && wiper_o[pot_r] != POTX_WIPER_MAX)
					wiper_o[pot_r] <= wiper_o[pot_r] + 6'h01;
				else if (!s_si && wiper_o[pot_r] != 6'h00)
					wiper_o[pot_r] <= wiper_o[pot_r] - 6'h01;
			end
			else if (exec && pend_op_r == POTX_OP_GRECALL)
			begin
				for (int p = 0; p < POTX_NPOT; p++)
					wiper_o[p] <= store_r[p][slot_r];
			end
			else if (exec && pend_op_r == POTX_OP_SRECALL)
				wiper_o[pot_r] <= store_r[pot_r][slot_r];
		end
	end

	// Stored settings
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			for (int p = 0; p < POTX_NPOT; p++)
				for (int s = 0; s < POTX_NSLOT; s++)
					store_r[p][s] <= POTX_STORE_RST;
		end
		else if (ce_i && save_go)
		begin
			if (pend_op_r == POTX_OP_GSAVE)
			begin
				for (int p = 0; p < POTX_NPOT; p++)
					store_r[p][slot_r] <= wiper_o[p];
			end
			else
				store_r[pot_r][slot_r] <= wiper_o[pot_r];
		end
	end

	// Programming cycle timer
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			write_busy_flag_o <= 1'b0;
			prog_cnt_r <= 17'h00000;
		end
		else if (ce_i)
		begin
			if (save_go)
			begin
				write_busy_flag_o <= 1'b1;
				prog_cnt_r <= 17'h00000;
			end
			else if (write_busy_flag_o)
			begin
				if (prog_cnt_r == 17'(PROG_CYC - 1))
					write_busy_flag_o <= 1'b0;
				else
					prog_cnt_r <= prog_cnt_r + 17'h00001;
			end
		end
	end
endmodule

// file: potx_host.sv
// Controller end: Avalon-MM registers driving the serial frames
module potx_host
	import potx_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic irq_o,
	potx_if.host link
);
	import potx_pkg::*;

	typedef enum logic [4:0] {
		HS_IDLE = 5'b00001,
		HS_LOW = 5'b00010,
		HS_HIGH = 5'b00100,
		HS_TRAIL = 5'b01000,
		HS_GAP = 5'b10000
	} potx_hstate_t;

	potx_hstate_t st_r;
	logic so_s;
	logic cs_n_r;
	logic sck_r;
	logic si_r;
	logic [31:0] tx_r;
	logic [7:0] rx_r;
	logic [5:0] len_r;
	logic [5:0] bit_r;
	logic [3:0] div_r;
	logic is_stat_r;
	logic [7:0] status_byte_r;
	logic done_r;
	logic mask_r;
	logic acc;
	logic ctrl_wr;
	logic frame_end;
	logic half_done;
	logic cmd_ok;
	logic [7:0] instr;
	logic [2:0] c_op;
	logic [1:0] c_slot;
	logic [1:0] c_pot;

	potx_sync #(
		.W(1),
		.RST_VAL(1'b0)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.d_i(link.so),
		.q_o(so_s)
	);

	assign link.cs_n = cs_n_r;
	assign link.sck = sck_r;
	assign link.si = si_r;
	assign acc = (avs_read_i | avs_write_i) & avs_waitrequest_o;
	// Writes land at the acknowledge edge, when the master sees them done
	assign ctrl_wr = avs_write_i & ~avs_waitrequest_o
		& (avs_address_i == POTX_REG_CTRL);
	assign half_done = (div_r == POTX_SCK_HALF - 4'h1);
	assign frame_end = (st_r == HS_TRAIL) & half_done;
	assign c_op = avs_writedata_i[POTX_CTRL_OP_LSB +: 3];
	assign c_slot = avs_writedata_i[POTX_CTRL_SLOT_LSB +: 2];
	assign c_pot = avs_writedata_i[POTX_CTRL_POT_LSB +: 2];

	always_comb
	begin
		cmd_ok = 1'b1;
		instr = POTX_OP_STATUS;
		case (c_op)
			POTX_CMD_STATUS: instr = POTX_OP_STATUS;
			POTX_CMD_GRECALL: instr = {POTX_OP_GRECALL, c_slot, 2'h0};
			POTX_CMD_GSAVE: instr = {POTX_OP_GSAVE, c_slot, 2'h0};
			POTX_CMD_SSAVE: instr = {POTX_OP_SSAVE, c_slot, c_pot};
			POTX_CMD_SRECALL: instr = {POTX_OP_SRECALL, c_slot, c_pot};
			POTX_CMD_STEP: instr = {POTX_OP_STEP, c_pot};
			default: cmd_ok = 1'b0;
		endcase
	end

	// Bus answer: one wait cycle, then a single-cycle acknowledge
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o <= 32'h00000000;
			mask_r <= POTX_IRQ_MASK_RST;
		end
		else if (ce_i)
		begin
			avs_waitrequest_o <= ~acc;
			if (acc && avs_read_i)
			begin
				avs_readdata_o <= 32'h00000000;
				case (avs_address_i)
					POTX_REG_STATUS:
					begin
						avs_readdata_o[POTX_STAT_BUSY_BIT] <= (st_r != HS_IDLE);
						avs_readdata_o[POTX_STAT_BYTE_LSB +: 8] <= status_byte_r;
					end
					POTX_REG_IRQ_STAT: avs_readdata_o[0] <= done_r;
					POTX_REG_IRQ_MASK: avs_readdata_o[0] <= mask_r;
					default: avs_readdata_o <= 32'h00000000;
				endcase
			end
			if (avs_write_i && !avs_waitrequest_o
				&& avs_address_i == POTX_REG_IRQ_MASK)
				mask_r <= avs_writedata_i[0];
		end
	end

	// Done flag: a frame end in the clearing read cycle wins
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			done_r <= 1'b0;
			irq_o <= 1'b0;
		end
		else if (ce_i)
		begin
			if (frame_end)
				done_r <= 1'b1;
			else if (acc && avs_read_i && avs_address_i == POTX_REG_IRQ_STAT)
				done_r <= 1'b0;
			irq_o <= done_r & mask_r;
		end
	end

	// Frame sequencer; orders arriving mid-frame are dropped
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			st_r <= HS_IDLE;
			cs_n_r <= 1'b1;
			sck_r <= 1'b0;
			si_r <= 1'b0;
			tx_r <= 32'h00000000;
			rx_r <= 8'h00;
			len_r <= 6'h00;
			bit_r <= 6'h00;
			div_r <= 4'h0;
			is_stat_r <= 1'b0;
			status_byte_r <= 8'h00;
		end
		else if (ce_i)
		begin
			div_r <= (st_r == HS_IDLE || half_done) ? 4'h0 : div_r + 4'h1;
			unique case (st_r)
				HS_IDLE:
					if (ctrl_wr && cmd_ok)
					begin
						tx_r <= {POTX_ADDR_PREFIX,
							avs_writedata_i[POTX_CTRL_DEV_LSB +: 2], instr,
							{16{avs_writedata_i[POTX_CTRL_DIR_BIT]}}};
						si_r <= POTX_ADDR_PREFIX[5];
						cs_n_r <= 1'b0;
						bit_r <= 6'h00;
						is_stat_r <= (c_op == POTX_CMD_STATUS);
						if (c_op == POTX_CMD_STATUS)
							len_r <= 6'd24;
						else if (c_op == POTX_CMD_STEP)
							len_r <= 6'd16 + {2'h0,
								avs_writedata_i[POTX_CTRL_STEPS_LSB +: 4]};
						else
							len_r <= 6'd16;
						st_r <= HS_LOW;
					end
				HS_LOW:
					if (half_done)
					begin
						sck_r <= 1'b1;
						rx_r <= {rx_r[6:0], so_s};
						st_r <= HS_HIGH;
					end
				HS_HIGH:
					if (half_done)
					begin
						sck_r <= 1'b0;
						tx_r <= {tx_r[30:0], 1'b0};
						si_r <= tx_r[30];
						bit_r <= bit_r + 6'h01;
						st_r <= (bit_r == len_r - 6'h01) ? HS_TRAIL : HS_LOW;
					end
				HS_TRAIL:
					if (half_done)
					begin
						cs_n_r <= 1'b1;
						si_r <= 1'b0;
						if (is_stat_r)
							status_byte_r <= rx_r;
						st_r <= HS_GAP;
					end
				HS_GAP:
					if (half_done)
						st_r <= HS_IDLE;
			endcase
		end
	end
endmodule

// file: potx_assertions.sv
// Wire and device-state checks for the potentiometer serial link
module potx_assertions
	import potx_pkg::*;
#(
	parameter int PROG_CYC = 20
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	input wire logic so,
	input wire logic write_busy_flag_o,
	input wire potx_pkg::potx_wipers_t wiper_o
);
	logic [31:0] busy_cnt_r;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// Length of the current programming cycle; a run-away busy shows here
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			busy_cnt_r <= '0;
		else if (write_busy_flag_o)
			busy_cnt_r <= busy_cnt_r + 32'h1;
		else
			busy_cnt_r <= '0;
	end

	chk_sck_idle_low: assert property (cs_n |-> !sck)
		else $error("serial clock moved outside a frame");
	chk_so_idle_zero: assert property (cs_n |-> !so)
		else $error("data out active outside a frame");
	chk_si_stable_high: assert property (sck |-> $stable(si))
		else $error("data in changed while clock high");
	chk_cs_setup: assert property ($fell(cs_n) |-> !sck [*8])
		else $error("clock rose too soon after select");
	chk_sck_phase: assert property ($rose(sck) |-> sck [*8] ##1 !sck)
		else $error("clock high phase not eight cycles");
	chk_cs_gap: assert property ($rose(cs_n) |-> cs_n [*8])
		else $error("select idle gap too short");
	chk_busy_start: assert property ($rose(write_busy_flag_o)
		|-> cs_n && $past(cs_n, 3))
		else $error("programming began inside a frame");
	chk_busy_hold: assert property ($rose(write_busy_flag_o)
		|-> write_busy_flag_o [*8])
		else $error("busy flag dropped early");
	chk_busy_bound: assert property (busy_cnt_r <= PROG_CYC)
		else $error("programming cycle ran too long");
	chk_wiper_in_sck: assert property ($changed(wiper_o) && !cs_n |-> sck)
		else $error("wiper moved outside a clock pulse");
endmodule

// file: potx_tb.sv
// Self-checking bench: controller and device joined over the serial link
module potx_tb
	import potx_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// Long enough that a status frame lands inside a programming cycle
	localparam int PROG = 1000;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [3:0] av_a = '0;
	logic av_r = 1'b0;
	logic av_w = 1'b0;
	logic [31:0] av_d = '0;
	logic [31:0] av_q;
	logic av_wait;
	logic irq;
	logic busy;
	potx_wipers_t write_busy_flag;
	potx_wipers_t exp_w = '0;
	int num_errors = 0;
	int num_checks = 0;
	int cyc = 0;
	int i;

	potx_if lnk();
	potx_host u_potx_host (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
		.avs_address_i(av_a), .avs_read_i(av_r), .avs_write_i(av_w),
		.avs_writedata_i(av_d), .avs_readdata_o(av_q),
		.avs_waitrequest_o(av_wait), .irq_o(irq), .link(lnk.host));
	potx_dev #(.PROG_CYC(PROG)) u_potx_dev (.clk_i(clk_i), .rst_i(rst_i),
		.ce_i(1'b1), .link(lnk.dev), .addr_pin_high_i(1'b0),
		.addr_pin_low_i(1'b0), .wiper_o(write_busy_flag), .write_busy_flag_o(busy));
	potx_assertions #(.PROG_CYC(PROG)) u_potx_assertions (.clk_i(clk_i),
		.rst_i(rst_i), .cs_n(lnk.cs_n), .sck(lnk.sck), .si(lnk.si),
		.so(lnk.so), .write_busy_flag_o(busy), .wiper_o(write_busy_flag));

	initial
	begin
		forever #25 clk_i = ~clk_i;
	end

	task complete_run;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			num_errors++;
			complete_run();
		end
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		av_a <= a;
		av_d <= d;
		av_w <= wr;
		av_r <= !wr;
		do
			@(posedge clk_i);
		while (av_wait !== 1'b0);
		av_w <= 1'b0;
		av_r <= 1'b0;
	endtask

	task rd(input logic [3:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(av_q, exp);
	endtask

	function automatic logic [31:0] ctl(input int op, input int slot,
		input int pot, input int up, input int n);
		return 32'(op | (slot << POTX_CTRL_SLOT_LSB) |
			(pot << POTX_CTRL_POT_LSB) | (up << POTX_CTRL_DIR_BIT) |
			(n << POTX_CTRL_STEPS_LSB));
	endfunction

	// Frame done is awaited on the interrupt, then its sticky bit cleared
	task run_cmd(input logic [31:0] c);
		int n;
		bus(1'b1, POTX_REG_CTRL, c);
		for (n = 0; n < 3000 && irq !== 1'b1; n++)
			@(posedge clk_i);
		check({31'h0, irq}, 32'h1);
		rd(POTX_REG_IRQ_STAT, 32'h1);
		repeat (2)
			@(posedge clk_i);
		check({31'h0, irq}, 32'h0);
	endtask

	task idle_chk;
		int n;
		for (n = 0; n < 2 * PROG && busy !== 1'b0; n++)
			@(posedge clk_i);
		check({31'h0, busy}, 32'h0);
		check({8'h0, write_busy_flag}, {8'h0, exp_w});
	endtask

	task step(input int pot, input int up, input int n);
		int v;
		run_cmd(ctl(5, 0, pot, up, n));
		v = int'(exp_w[pot]) + (up != 0 ? n : -n);
		exp_w[pot] = (v > 63) ? 6'h3f : (v < 0) ? 6'h00 : 6'(v);
		idle_chk();
	endtask

	initial
	begin
		repeat (2)
			@(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3)
			@(posedge clk_i);
		check({30'h0, lnk.cs_n, lnk.sck}, 32'h2);
		idle_chk();
		rd(POTX_REG_STATUS, 32'h0);
		rd(4'h1, 32'h0);
		bus(1'b1, POTX_REG_IRQ_MASK, 32'h1);
		rd(POTX_REG_IRQ_MASK, 32'h1);
		step(2, 1, 5);
		step(1, 0, 3);
		step(3, 1, 2);
		for (i = 0; i < 5; i++)
			step(0, 1, 15);
		run_cmd(ctl(2, 1, 0, 0, 0));
		check({31'h0, busy}, 32'h1);
		run_cmd(ctl(0, 0, 0, 0, 0));
		rd(POTX_REG_STATUS, 32'h2);
		idle_chk();
		run_cmd(ctl(0, 0, 0, 0, 0));
		rd(POTX_REG_STATUS, 32'h0);
		step(2, 1, 3);
		run_cmd(ctl(3, 2, 2, 0, 0));
		idle_chk();
		run_cmd(ctl(1, 1, 0, 0, 0));
		exp_w[2] = 6'h05;
		idle_chk();
		run_cmd(ctl(4, 2, 2, 0, 0));
		exp_w[2] = 6'h08;
		idle_chk();
		run_cmd(ctl(1, 0, 0, 0, 0));
		exp_w = '0;
		idle_chk();
		run_cmd(ctl(5, 0, 2, 1, 1) | 32'h1000);
		idle_chk();
		complete_run();
	end
endmodule
